// file: logic/eda_nv_access.sv
// Register front end and storage for the byte-wide nonvolatile data array
//
// Behaviour
// - Array of 64 bytes, reached only via registers
// - One byte per access; sector placement of registers
// - Address and data registers are directly addressable
// - Address register: six bits, top two zero
// - Data register: full byte, resets to zero
// - Control bits 7..4 read zero; reset zero
// - Write permit clear blocks every write start; a running write completes
// - Write trigger starts write, hardware clears it
// - Write trigger ignored unless permit set before
// - Read permit clear blocks every read start; a running read completes
// - Read trigger gated, self clears, data held
// - Write end sets sticky done flag and a one-cycle request pulse
`timescale 1ns/100ps
`default_nettype none
module eda_nv_access import eda_pkg::*; #(
    parameter int WRITE_CYCLES = EDA_WRITE_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic sfr_sector_in,
    input wire logic [7:0] sfr_offset_in,
    input wire logic sfr_write_in,
    input wire logic sfr_read_in,
    input wire logic [7:0] sfr_wdata_in,
    output var logic [7:0] sfr_rdata_out,
    input wire logic write_done_clear_in,
    output var logic write_done_flag_out,
    output var logic mf_request_out,
    output logic busy_out
);
    // Cycle counter width covers the longest timed cycle
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_CYCLES - 1);
    localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(EDA_READ_CYCLES - 1);

    logic [7:0] mem [EDA_DEPTH]; // The byte array itself
    logic [EDA_ADDR_BITS-1:0] nv_address; // Software address register
    logic [7:0] nv_data; // Software data register
    logic write_permit; // Control bit 3
    logic write_trigger; // Control bit 2, busy while writing
    logic read_permit; // Control bit 1
    logic read_trigger; // Control bit 0, busy while reading
    eda_state_t state; // Access cycle state
    logic [CNT_W-1:0] cycle_count; // Timer for the running cycle
    logic [EDA_ADDR_BITS-1:0] cycle_addr; // Address frozen at cycle start
    logic [7:0] cycle_data; // Byte frozen at write start

    // Register decode strobes
    logic hit_address;
    logic hit_data;
    logic hit_control;
    logic wr_address;
    logic wr_data;
    logic wr_control;
    logic write_go;
    logic read_go;
    logic write_end;
    logic read_end;

    // Address compare per register
    assign hit_address = (sfr_sector_in == EDA_SECTOR_DIRECT) && (sfr_offset_in == EDA_OFS_ADDRESS);
    assign hit_data = (sfr_sector_in == EDA_SECTOR_DIRECT) && (sfr_offset_in == EDA_OFS_DATA);
    assign hit_control = (sfr_sector_in == EDA_SECTOR_CONTROL) && (sfr_offset_in == EDA_OFS_CONTROL);
    assign wr_address = sfr_write_in && hit_address;
    assign wr_data = sfr_write_in && hit_data;
    assign wr_control = sfr_write_in && hit_control;

    // Start only from idle and only with the permit already stored
    assign write_go = wr_control && sfr_wdata_in[EDA_BIT_WRITE_TRIGGER] && write_permit
                      && (state == EDA_IDLE);
    // Write wins if both triggers arrive together
    assign read_go = wr_control && sfr_wdata_in[EDA_BIT_READ_TRIGGER] && read_permit
                     && (state == EDA_IDLE) && !write_go;
    assign write_end = (state == EDA_WRITING) && (cycle_count == WRITE_LAST);
    assign read_end = (state == EDA_READING) && (cycle_count == READ_LAST);
    assign busy_out = (state != EDA_IDLE);

    // Address register, upper bits not stored
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            nv_address <= EDA_RESET_ADDRESS[EDA_ADDR_BITS-1:0];
        end else if (wr_address) begin
            nv_address <= sfr_wdata_in[EDA_ADDR_BITS-1:0];
        end
    end

    // Data register: software load, or read result at cycle end
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            nv_data <= EDA_RESET_DATA;
        end else if (read_end) begin
            nv_data <= mem[cycle_addr];
        end else if (wr_data) begin
            nv_data <= sfr_wdata_in;
        end
    end

    // Permit bits are plain software bits
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            write_permit <= EDA_RESET_CONTROL[EDA_BIT_WRITE_PERMIT];
            read_permit <= EDA_RESET_CONTROL[EDA_BIT_READ_PERMIT];
        end else if (wr_control) begin
            write_permit <= sfr_wdata_in[EDA_BIT_WRITE_PERMIT];
            read_permit <= sfr_wdata_in[EDA_BIT_READ_PERMIT];
        end
    end

    // Trigger bits: set by an accepted start, cleared by hardware only
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            write_trigger <= EDA_RESET_CONTROL[EDA_BIT_WRITE_TRIGGER];
            read_trigger <= EDA_RESET_CONTROL[EDA_BIT_READ_TRIGGER];
        end else begin
            if (write_go) begin
                write_trigger <= 1'h1;
            end else if (write_end) begin
                write_trigger <= 1'h0;
            end
            if (read_go) begin
                read_trigger <= 1'h1;
            end else if (read_end) begin
                read_trigger <= 1'h0;
            end
        end
    end

    // Cycle sequencer and timer, independent of instruction flow
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state <= EDA_IDLE;
            cycle_count <= '0;
        end else begin
            case (state)
                EDA_IDLE: begin
                    cycle_count <= '0;
                    if (write_go) begin
                        state <= EDA_WRITING;
                    end else if (read_go) begin
                        state <= EDA_READING;
                    end
                end
                EDA_WRITING: begin
                    if (write_end) begin
                        state <= EDA_IDLE;
                    end else begin
                        cycle_count <= cycle_count + 1'h1;
                    end
                end
                EDA_READING: begin
                    if (read_end) begin
                        state <= EDA_IDLE;
                    end else begin
                        cycle_count <= cycle_count + 1'h1;
                    end
                end
                default: begin
                    state <= EDA_IDLE;
                end
            endcase
        end
    end

    // Snapshot of address and byte taken only at cycle start
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cycle_addr <= '0;
            cycle_data <= '0;
        end else if (write_go || read_go) begin
            cycle_addr <= nv_address;
            cycle_data <= nv_data;
        end
    end

    // Array update, reached only through a permitted write cycle
    always_ff @(posedge clock_in) begin
        if (write_end) begin
            mem[cycle_addr] <= cycle_data;
        end
    end

    // Completion flags; a new completion beats a clear
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            write_done_flag_out <= 1'h0;
            mf_request_out <= 1'h0;
        end else begin
            mf_request_out <= write_end;
            if (write_end) begin
                write_done_flag_out <= 1'h1;
            end else if (write_done_clear_in) begin
                write_done_flag_out <= 1'h0;
            end
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_read_in) begin
            if (hit_address) begin
                sfr_rdata_out <= {2'h0, nv_address};
            end else if (hit_data) begin
                sfr_rdata_out <= nv_data;
            end else if (hit_control) begin
                sfr_rdata_out <= {4'h0, write_permit, write_trigger, read_permit, read_trigger};
            end else begin
                sfr_rdata_out <= 8'h00;
            end
        end
    end

    // Steps of a read cycle as seen on the trigger bit
    sequence seq_read_start;
        read_go;
    endsequence
    sequence seq_read_busy_then_done;
        read_trigger ##1 read_trigger ##1 !read_trigger;
    endsequence

    AST_ADDR_UPPER_ZERO:
        assert property (@(posedge clock_in) disable iff (reset_in)
            sfr_read_in && hit_address |=> sfr_rdata_out[7:6] == 2'h0)
        else $error("address register upper bits not zero");

    AST_CTRL_UPPER_ZERO:
        assert property (@(posedge clock_in) disable iff (reset_in)
            sfr_read_in && hit_control |=> sfr_rdata_out[7:4] == 4'h0)
        else $error("control register upper bits not zero");

    AST_WRITE_BLOCKED:
        assert property (@(posedge clock_in) disable iff (reset_in)
            wr_control && sfr_wdata_in[EDA_BIT_WRITE_TRIGGER] && !write_permit && state == EDA_IDLE
            |=> !write_trigger && state == EDA_IDLE)
        else $error("write started without permit");

    AST_READ_BLOCKED:
        assert property (@(posedge clock_in) disable iff (reset_in)
            wr_control && sfr_wdata_in[EDA_BIT_READ_TRIGGER] && !read_permit && !write_go
            && state == EDA_IDLE |=> !read_trigger && state == EDA_IDLE)
        else $error("read started without permit");

    AST_WRITE_HELD:
        assert property (@(posedge clock_in) disable iff (reset_in)
            write_go |=> (write_trigger && state == EDA_WRITING) [*8])
        else $error("write trigger dropped early");

    AST_WRITE_FINISH:
        assert property (@(posedge clock_in) disable iff (reset_in)
            state == EDA_WRITING && cycle_count == WRITE_LAST |=> !write_trigger && mf_request_out)
        else $error("write cycle did not finish on time");

    AST_READ_FINISH:
        assert property (@(posedge clock_in) disable iff (reset_in)
            seq_read_start |=> seq_read_busy_then_done)
        else $error("read cycle length wrong");

    AST_READ_DATA:
        assert property (@(posedge clock_in) disable iff (reset_in)
            read_end |=> nv_data == mem[cycle_addr])
        else $error("read byte not loaded");

    AST_ADDR_FROZEN:
        assert property (@(posedge clock_in) disable iff (reset_in)
            state != EDA_IDLE |=> $stable(cycle_addr))
        else $error("cycle address changed mid cycle");

    AST_DONE_STICKY:
        assert property (@(posedge clock_in) disable iff (reset_in)
            write_done_flag_out && !write_done_clear_in |=> write_done_flag_out)
        else $error("done flag lost without clear");

    AST_DONE_WITH_REQUEST:
        assert property (@(posedge clock_in) disable iff (reset_in)
            mf_request_out |-> write_done_flag_out)
        else $error("request without done flag");

    // Busy shows exactly while a trigger bit is up
    AST_BUSY_IS_TRIGGER:
        assert property (@(posedge clock_in) disable iff (reset_in)
            busy_out == (write_trigger || read_trigger))
        else $error("busy and trigger bits disagree");

    // Data register moves only on a software load or a read result
    AST_DATA_HELD:
        assert property (@(posedge clock_in) disable iff (reset_in)
            !wr_data && !read_end |=> $stable(nv_data))
        else $error("data register changed with no cause");

    // Request is a single-cycle pulse
    AST_REQUEST_PULSE:
        assert property (@(posedge clock_in) disable iff (reset_in)
            mf_request_out |=> !mf_request_out)
        else $error("request longer than one cycle");

    // Address register takes the low six bits of a write
    AST_ADDR_LOAD:
        assert property (@(posedge clock_in) disable iff (reset_in)
            wr_address |=> nv_address == EDA_ADDR_BITS'($past(sfr_wdata_in)))
        else $error("address register not loaded");
endmodule
`default_nettype wire

// file: logic/eda_pkg.sv
// Constants shared by the nonvolatile data access front end
`default_nettype none
package eda_pkg;
    // Register placement: sector select plus offset within the sector
    localparam logic EDA_SECTOR_DIRECT = 1'h0;
    localparam logic EDA_SECTOR_CONTROL = 1'h1;
    localparam logic [7:0] EDA_OFS_ADDRESS = 8'h1e;
    localparam logic [7:0] EDA_OFS_DATA = 8'h1f;
    localparam logic [7:0] EDA_OFS_CONTROL = 8'h40;
    // Control register field positions
    localparam int EDA_BIT_WRITE_PERMIT = 3;
    localparam int EDA_BIT_WRITE_TRIGGER = 2;
    localparam int EDA_BIT_READ_PERMIT = 1;
    localparam int EDA_BIT_READ_TRIGGER = 0;
    // Address field width and array depth
    localparam int EDA_ADDR_BITS = 6;
    localparam int EDA_DEPTH = 64;
    // Reset values
    localparam logic [7:0] EDA_RESET_ADDRESS = 8'h00;
    localparam logic [7:0] EDA_RESET_DATA = 8'h00;
    localparam logic [3:0] EDA_RESET_CONTROL = 4'h0;
    // Timing: clock rate and write time in their own units
    localparam int EDA_CLOCK_MHZ = 250;
    localparam int EDA_WRITE_TIME_US = 4000;
    localparam int EDA_WRITE_CYCLES = EDA_WRITE_TIME_US * EDA_CLOCK_MHZ;
    localparam int EDA_READ_CYCLES = 2;
    // Access cycle states
    typedef enum logic [1:0] {
        EDA_IDLE,
        EDA_READING,
        EDA_WRITING
    } eda_state_t;
endpackage
`default_nettype wire

// file: verif/eda_host.sv
// Host model: CPU core reaching the access front end's registers
`timescale 1ns/100ps
`default_nettype none
module eda_host import eda_pkg::*; (
    input wire logic clock_in,
    input wire logic [7:0] rdata_in,
    output logic sector_out,
    output logic [7:0] offset_out,
    output logic write_out,
    output logic read_out,
    output logic [7:0] wdata_out
);
    // Idle bus at time zero
    initial begin
        sector_out = 1'h0;
        offset_out = 8'h00;
        write_out = 1'h0;
        read_out = 1'h0;
        wdata_out = 8'h00;
    end
    // One strobed access, qualifiers held through the taking edge
    task automatic access(input logic sec, input logic [7:0] ofs, input logic wr, input logic [7:0] wd);
        @(posedge clock_in);
        sector_out <= sec;
        offset_out <= ofs;
        wdata_out <= wd;
        write_out <= wr;
        read_out <= ~wr;
        @(posedge clock_in);
        write_out <= 1'h0;
        read_out <= 1'h0;
        // Released qualifiers no longer show the old value
        offset_out <= ~ofs;
        wdata_out <= ~wd;
    endtask
    task automatic wr_reg(input logic sec, input logic [7:0] ofs, input logic [7:0] wd);
        access(sec, ofs, 1'h1, wd);
    endtask
    // Read data is registered, so it is taken one edge later
    task automatic rd_reg(input logic sec, input logic [7:0] ofs, output logic [7:0] rd);
        access(sec, ofs, 1'h0, 8'h00);
        @(posedge clock_in);
        rd = rdata_in;
    endtask
    // Control register via pointer 0x40 in sector 1
    task automatic wr_ctrl(input logic [7:0] wd);
        wr_reg(EDA_SECTOR_CONTROL, EDA_OFS_CONTROL, wd);
    endtask
    // Write: address, data, permit, then trigger at once after
    task automatic write_cell(input logic [7:0] a, input logic [7:0] d);
        wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_ADDRESS, a);
        wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_DATA, d);
        wr_ctrl(8'h08);
        wr_ctrl(8'h0c);
    endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the nonvolatile data access front end
`timescale 1ns/100ps
`default_nettype none
module testbench import eda_pkg::*; ();
    localparam int W = 20; // Short write time for simulation
    logic clock_in, reset_in, sec, wr, rd, clr, done, mf, busy;
    logic [7:0] ofs, wd, rdata;
    int n_errors = 0;
    int checks_done = 0;
    int mf_count = 0;
    // 250 MHz clock
    initial begin
        clock_in = 1'h0;
        forever #2 clock_in = ~clock_in;
    end
    eda_nv_access #(.WRITE_CYCLES(W)) DUT (.clock_in(clock_in), .reset_in(reset_in), .sfr_sector_in(sec),
        .sfr_offset_in(ofs), .sfr_write_in(wr), .sfr_read_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdata),
        .write_done_clear_in(clr), .write_done_flag_out(done), .mf_request_out(mf), .busy_out(busy));
    eda_host host (.clock_in(clock_in), .rdata_in(rdata), .sector_out(sec), .offset_out(ofs),
        .write_out(wr), .read_out(rd), .wdata_out(wd));
    // Counts request pulses
    always @(posedge clock_in) begin
        if (mf === 1'h1) mf_count <= mf_count + 1;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    // Read a direct register and compare
    task automatic rd_dir(input string what, input logic [7:0] o, input logic [7:0] exp);
        logic [7:0] r;
        host.rd_reg(EDA_SECTOR_DIRECT, o, r);
        check(what, exp, r);
    endtask
    // Read the control register and compare
    task automatic rd_ctrl(input string what, input logic [7:0] exp);
        logic [7:0] r;
        host.rd_reg(EDA_SECTOR_CONTROL, EDA_OFS_CONTROL, r);
        check(what, exp, r);
    endtask
    // Bounded wait for the access cycle to end
    task automatic wait_idle;
        int n;
        n = 0;
        #1;
        while (busy === 1'h1 && n < 1000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        // A cycle that never ends counts against the run
        check("idle", 8'h00, {7'h00, busy});
    endtask
    task automatic t_reset_values;
        rd_dir("address", EDA_OFS_ADDRESS, 8'h00);
        rd_dir("data", EDA_OFS_DATA, 8'h00);
        rd_ctrl("control", 8'h00);
        rd_dir("unmapped", 8'h00, 8'h00);
        check("flags", 8'h00, {5'h00, done, mf, busy});
    endtask
    task automatic t_reg_fields;
        host.wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_ADDRESS, 8'hff);
        rd_dir("address", EDA_OFS_ADDRESS, 8'h3f);
        host.wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_DATA, 8'ha5);
        rd_dir("data", EDA_OFS_DATA, 8'ha5);
        // Right offset in the wrong sector reaches nothing
        host.wr_reg(EDA_SECTOR_CONTROL, EDA_OFS_ADDRESS, 8'h00);
        rd_dir("address_sector", EDA_OFS_ADDRESS, 8'h3f);
        host.wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_CONTROL, 8'h0a);
        rd_ctrl("control_sector", 8'h00);
        rd_dir("control_direct", EDA_OFS_CONTROL, 8'h00);
        host.wr_ctrl(8'hf2);
        rd_ctrl("control", 8'h02);
        host.wr_ctrl(8'h00);
    endtask
    // Triggers without a stored permit start nothing
    task automatic t_gated;
        host.wr_ctrl(8'h04);
        rd_ctrl("control", 8'h00);
        host.wr_ctrl(8'h0c);
        rd_ctrl("control", 8'h08);
        host.wr_ctrl(8'h01);
        rd_ctrl("control", 8'h00);
        rd_dir("data", EDA_OFS_DATA, 8'ha5);
        check("done", 8'h00, {7'h00, done});
        check("requests", 8'h00, mf_count[7:0]);
    endtask
    // Timed write; optionally a clear held across its end, which the set beats
    task automatic t_write(input logic [7:0] a, input logic [7:0] d, input logic clr_during);
        time t0;
        int cyc, m0;
        m0 = mf_count;
        host.write_cell(a, d);
        t0 = $time;
        host.wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_ADDRESS, ~a);
        rd_ctrl("control_busy", 8'h0c);
        clr <= clr_during;
        wait_idle();
        cyc = int'(($time - t0) / 4);
        check("write_time", 8'(W), 8'(cyc));
        check("done", 8'h01, {7'h00, done});
        check("request_pulse", 8'h01, {7'h00, mf});
        @(posedge clock_in);
        clr <= 1'h0;
        #1;
        check("request_end", 8'h00, {7'h00, mf});
        check("requests", 8'h01, 8'(mf_count - m0));
        check("done_after_clear", {7'h00, !clr_during}, {7'h00, done});
        rd_ctrl("control_end", 8'h08);
        rd_dir("data", EDA_OFS_DATA, d);
        check("done_held", {7'h00, !clr_during}, {7'h00, done});
        @(posedge clock_in);
        clr <= 1'h1;
        @(posedge clock_in);
        clr <= 1'h0;
        #1;
        check("done_cleared", 8'h00, {7'h00, done});
        host.wr_ctrl(8'h00);
    endtask
    task automatic t_read(input logic [7:0] a, input logic [7:0] d);
        host.wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_ADDRESS, a);
        host.wr_ctrl(8'h02);
        host.wr_ctrl(8'h03);
        host.wr_reg(EDA_SECTOR_DIRECT, EDA_OFS_ADDRESS, ~a);
        wait_idle();
        rd_ctrl("control_end", 8'h02);
        rd_dir("data_read", EDA_OFS_DATA, d);
        host.wr_ctrl(8'h00);
    endtask
    // Reset in mid-run clears registers and flags, not the array
    task automatic t_reset_again;
        @(posedge clock_in);
        reset_in <= 1'h1;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'h0;
        @(posedge clock_in);
        t_reset_values();
        t_read(8'h3f, 8'h5a);
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #100000;
        n_errors++;
        end_of_test();
    end
    // Main sequence
    initial begin
        reset_in = 1'h1;
        clr = 1'h0;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'h0;
        @(posedge clock_in);
        t_reset_values();
        t_reg_fields();
        t_gated();
        t_write(8'h3f, 8'h5a, 1'h0);
        t_write(8'h00, 8'hc3, 1'h1);
        t_read(8'h3f, 8'h5a);
        t_read(8'h00, 8'hc3);
        t_reset_again();
        end_of_test();
    end
endmodule
`default_nettype wire
